// *** verilog/rps_cfg.svh ***
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// ----------------------------------------
// time base
// ----------------------------------------
`define RPS_CLK_PERIOD_NS   10
`define RPS_TICK_NS         1000
`define RPS_TICK_CYCLES     (`RPS_TICK_NS / `RPS_CLK_PERIOD_NS)
`define RPS_START_DELAY_US  41
`define RPS_RST_DELAY_US    1000

// ----------------------------------------
// serial port
// ----------------------------------------
`define RPS_I2C_ADDR        7'h53
// identity value is arbitrary
`define RPS_ID_VALUE        8'h5C

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPS_REG_PRI_BASE    8'h00
`define RPS_REG_ALT_BASE    8'h04
`define RPS_REG_LIN_BASE    8'h08
`define RPS_REG_RAIL_STAT   8'h0B
`define RPS_REG_SEQ_STAT    8'h0C
`define RPS_REG_ID          8'h7D
`define RPS_NUM_RW_REGS     11

// ----------------------------------------
// reset codes (one per buck, shared by both sets)
// ----------------------------------------
`define RPS_BUCK_RAIL_1_RST       8'hFF
`define RPS_BUCK_RAIL_2_RST       8'h0F
`define RPS_BUCK_RAIL_3_RST       8'h1E
`define RPS_BUCK_RAIL_4_RST       8'h80
`define RPS_LIN1_RST        8'h00
`define RPS_LIN2_RST        8'h04
`define RPS_LIN3_RST        8'h00
`define RPS_LIN_CODE_MASK   8'h3F

// ----------------------------------------
// code decode, microvolts and millivolts
// ----------------------------------------
`define RPS_BUCK_BASE_UV    22'd600000
`define RPS_BUCK_STEP_UV    22'd9375
`define RPS_BUCK_TOP_UV     22'd3000000
`define RPS_LIN13_BASE_MV   12'd2000
`define RPS_LIN2_BASE_MV    12'd800
`define RPS_LIN_STEP_MV     12'd25

`endif

// *** verilog/rps_pkg.sv ***
package rps_pkg;

    typedef struct packed {
        logic [2:0][21:0] buck_uv;
        logic [7:0]       buck_rail_4_code;
        logic [2:0][11:0] lin_mv;
    } rps_vout_t;

    typedef enum logic [4:0] {
        SEQ_OFF   = 5'b00001,
        SEQ_DELAY = 5'b00010,
        SEQ_RAMP  = 5'b00100,
        SEQ_HOLD  = 5'b01000,
        SEQ_UP    = 5'b10000
    } rps_seq_state_t;

    typedef enum logic [4:0] {
        BUS_IDLE = 5'b00001,
        BUS_ADDR = 5'b00010,
        BUS_REG  = 5'b00100,
        BUS_WR   = 5'b01000,
        BUS_RD   = 5'b10000
    } rps_bus_state_t;

endpackage

// *** verilog/rps_sequencer.sv ***
`timescale 1ns/1ps
`include "rps_cfg.svh"
// Behaviour
// R01: trigger rise starts chain; each rail waits 41 us after its predecessor.
// R02: order buck_rail_1, buck_rail_2, buck_rail_3, linear1, linear2, buck_rail_4, linear3.
// R03: trigger fall turns every rail off at once.
// R04: system reset stays low, released 1 ms after linear3 regulates.
// R05: select low applies primary set to bucks, high applies alternate.
// R06: both voltage sets reset to identical codes per buck.
// R07: no sleep state; power enable input has no effect.
// R08: buck_rail_1-3 decode 0.6 V plus 9.375 mV per code, top 3.000 V.
// R09: linear1 and 3 decode 2.0 V plus 25 mV per code, top 3.575 V.
// R10: linear2 decodes 0.8 V plus 25 mV per code, top 2.375 V.
// R11: serial port answers at 7-bit address 0x53.
// R12: read-only identity register at offset 0x7D.
// R13: power good, supply ok, external enable, aux resets stay inactive.
// R14: board ties the mode pin low.
// R15: rail power-good inputs are synchronous; delays count time-base ticks.
module rps_sequencer #(
    parameter int START_DELAY_US = `RPS_START_DELAY_US,
    parameter int RST_DELAY_US   = `RPS_RST_DELAY_US
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              seq_trigger_i,
    input  wire logic              dvs_select_in_i,
    input  wire logic              power_enable_in_i,
    input  wire logic              mode_i,
    input  wire logic [6:0]        rail_pg_i,
    output logic      [6:0]        rail_en_o,
    output logic                   system_reset_out_n_o,
    output rps_pkg::rps_vout_t     vout_o,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    output logic                   power_good_pin_o,
    output logic                   input_supply_ok_pin_o,
    output logic                   external_supply_enable_o,
    output logic                   aux_reset_one_o,
    output logic                   aux_reset_two_o
);

    localparam int TICK_CYCLES = `RPS_TICK_CYCLES;
    localparam int LAST_RAIL   = 6;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic       trig_s;
    logic       dvs_s;
    logic       scl_s;
    logic       sda_s;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= 4'hF;
            sync2_ff <= 4'hF;
        end else begin
            sync1_ff <= {seq_trigger_i, dvs_select_in_i, scl_i, sda_i};
            sync2_ff <= sync1_ff;
        end
    end

    // trigger and select reset high through the synchroniser; that reset-high trigger is masked below as no rise
    assign trig_s = sync2_ff[3];
    assign dvs_s  = sync2_ff[2];
    assign scl_s  = sync2_ff[1];
    assign sda_s  = sync2_ff[0];

    // ----------------------------------------
    // time base
    // ----------------------------------------
    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic        tick;

    always_comb begin
        tick    = (div_ff == 16'(TICK_CYCLES - 1));
        nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // ----------------------------------------
    // power-up chain
    // ----------------------------------------
    rps_pkg::rps_seq_state_t seq_ff;
    rps_pkg::rps_seq_state_t nxt_seq;
    logic [2:0]  idx_ff;
    logic [2:0]  nxt_idx;
    logic [15:0] tcnt_ff;
    logic [15:0] nxt_tcnt;
    logic [6:0]  en_ff;
    logic [6:0]  nxt_en;
    logic        rstn_ff;
    logic        nxt_rstn;
    logic        trig_q_ff;
    logic        nxt_trig_q;

    always_comb begin
        nxt_seq    = seq_ff;
        nxt_idx    = idx_ff;
        nxt_tcnt   = tcnt_ff;
        nxt_en     = en_ff;
        nxt_rstn   = rstn_ff;
        nxt_trig_q = trig_s;
        // power_enable_in_i is deliberately unread: no sleep entry (see R07)
        if (!trig_s) begin
            nxt_seq  = rps_pkg::SEQ_OFF;                               // see R03
            nxt_en   = 7'h00;                                          // see R03
            nxt_rstn = 1'b0;
        end else begin
            unique case (seq_ff)
                rps_pkg::SEQ_OFF: begin
                    if (!trig_q_ff) begin
                        nxt_seq  = rps_pkg::SEQ_DELAY;                 // see R01
                        nxt_idx  = 3'd0;
                        nxt_tcnt = 16'h0000;
                    end
                end
                rps_pkg::SEQ_DELAY: begin
                    if (tick) begin                                    // see R15
                        if (tcnt_ff == 16'(START_DELAY_US - 1)) begin
                            nxt_en[idx_ff] = 1'b1;                     // see R01
                            nxt_seq        = rps_pkg::SEQ_RAMP;
                        end else begin
                            nxt_tcnt = tcnt_ff + 16'h0001;
                        end
                    end
                end
                rps_pkg::SEQ_RAMP: begin
                    if (rail_pg_i[idx_ff]) begin                       // see R15
                        nxt_tcnt = 16'h0000;
                        if (idx_ff == 3'(LAST_RAIL)) begin
                            nxt_seq = rps_pkg::SEQ_HOLD;
                        end else begin
                            nxt_idx = idx_ff + 3'd1;                   // see R02
                            nxt_seq = rps_pkg::SEQ_DELAY;
                        end
                    end
                end
                rps_pkg::SEQ_HOLD: begin
                    if (tick) begin
                        if (tcnt_ff == 16'(RST_DELAY_US - 1)) begin
                            nxt_rstn = 1'b1;                           // see R04
                            nxt_seq  = rps_pkg::SEQ_UP;
                        end else begin
                            nxt_tcnt = tcnt_ff + 16'h0001;
                        end
                    end
                end
                rps_pkg::SEQ_UP: begin
                    nxt_seq = rps_pkg::SEQ_UP;
                end
                default: begin
                    nxt_seq = rps_pkg::SEQ_OFF;
                    nxt_en  = 7'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_ff    <= rps_pkg::SEQ_OFF;
            idx_ff    <= 3'd0;
            tcnt_ff   <= 16'h0000;
            en_ff     <= 7'h00;
            rstn_ff   <= 1'b0;
            // high, so a trigger already high at reset needs a fresh rise
            trig_q_ff <= 1'b1;
        end else begin
            seq_ff    <= nxt_seq;
            idx_ff    <= nxt_idx;
            tcnt_ff   <= nxt_tcnt;
            en_ff     <= nxt_en;
            rstn_ff   <= nxt_rstn;
            trig_q_ff <= nxt_trig_q;
        end
    end

    assign rail_en_o            = en_ff;
    assign system_reset_out_n_o = rstn_ff;                             // see R04

    // pins of this option stay released; mode_i tied low by the board
    assign power_good_pin_o         = 1'b0;                            // see R13
    assign input_supply_ok_pin_o    = 1'b0;                            // see R13
    assign external_supply_enable_o = 1'b0;                            // see R13
    assign aux_reset_one_o          = 1'b0;                            // see R13
    assign aux_reset_two_o          = 1'b0;                            // see R13

    // ----------------------------------------
    // register file and serial slave
    // ----------------------------------------
    logic [7:0] regs_ff [`RPS_NUM_RW_REGS];
    logic [7:0] nxt_regs [`RPS_NUM_RW_REGS];
    rps_pkg::rps_bus_state_t bus_ff;
    rps_pkg::rps_bus_state_t nxt_bus;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] ptr_ff;
    logic [7:0] nxt_ptr;
    logic       drv_ff;
    logic       nxt_drv;
    logic       rw_ff;
    logic       nxt_rw;
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       rx_state;

    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input logic [7:0] r [`RPS_NUM_RW_REGS]);
        logic [7:0] d;
        d = 8'h00;
        if (a < 8'(`RPS_NUM_RW_REGS)) begin
            d = r[a[3:0]];
        end else if (a == `RPS_REG_RAIL_STAT) begin
            d = {1'b0, en_ff};
        end else if (a == `RPS_REG_SEQ_STAT) begin
            d = {rstn_ff, dvs_s, trig_s, seq_ff};
        end else if (a == `RPS_REG_ID) begin
            d = `RPS_ID_VALUE;                                         // see R12
        end
        return d;
    endfunction

    always_comb begin
        scl_rise  = scl_s & ~scl_q_ff;
        scl_fall  = ~scl_s & scl_q_ff;
        bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
        bus_stop  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
        rx_state  = (bus_ff == rps_pkg::BUS_ADDR) || (bus_ff == rps_pkg::BUS_REG) ||
                    (bus_ff == rps_pkg::BUS_WR);
        nxt_regs  = regs_ff;
        nxt_bus   = bus_ff;
        nxt_sh    = sh_ff;
        nxt_cnt   = cnt_ff;
        nxt_ptr   = ptr_ff;
        nxt_drv   = drv_ff;
        nxt_rw    = rw_ff;
        if (bus_start) begin
            nxt_bus = rps_pkg::BUS_ADDR;
            nxt_cnt = 4'd0;
            nxt_drv = 1'b0;
        end else if (bus_stop) begin
            nxt_bus = rps_pkg::BUS_IDLE;
            nxt_drv = 1'b0;
        end else if (scl_rise) begin
            if (rx_state && cnt_ff < 4'd8) begin
                nxt_sh  = {sh_ff[6:0], sda_s};
                nxt_cnt = cnt_ff + 4'd1;
            end else if (bus_ff == rps_pkg::BUS_RD && cnt_ff < 4'd8) begin
                nxt_cnt = cnt_ff + 4'd1;
            end else if (bus_ff == rps_pkg::BUS_RD && cnt_ff == 4'd8) begin
                if (sda_s) begin
                    nxt_bus = rps_pkg::BUS_IDLE;                       // master ended read
                end else begin
                    nxt_ptr = ptr_ff + 8'h01;
                    nxt_sh  = read_reg(ptr_ff + 8'h01, regs_ff);
                    nxt_cnt = 4'd9;
                end
            end
        end else if (scl_fall) begin
            if (rx_state && cnt_ff == 4'd8) begin
                nxt_cnt = 4'd9;
                nxt_drv = 1'b1;
                unique case (bus_ff)
                    rps_pkg::BUS_ADDR: begin
                        nxt_rw = sh_ff[0];
                        if (sh_ff[7:1] != `RPS_I2C_ADDR) begin         // see R11
                            nxt_bus = rps_pkg::BUS_IDLE;
                            nxt_drv = 1'b0;
                        end
                    end
                    rps_pkg::BUS_REG: begin
                        nxt_ptr = sh_ff;
                    end
                    default: begin
                        if (ptr_ff < 8'(`RPS_NUM_RW_REGS)) begin
                            nxt_regs[ptr_ff[3:0]] = (ptr_ff >= `RPS_REG_LIN_BASE) ?
                                                    (sh_ff & `RPS_LIN_CODE_MASK) : sh_ff;
                        end
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                endcase
            end else if (rx_state && cnt_ff == 4'd9) begin
                nxt_cnt = 4'd0;
                nxt_drv = 1'b0;
                if (bus_ff == rps_pkg::BUS_ADDR && rw_ff) begin
                    nxt_bus = rps_pkg::BUS_RD;
                    nxt_sh  = read_reg(ptr_ff, regs_ff);
                    nxt_drv = ~nxt_sh[7];
                end else if (bus_ff == rps_pkg::BUS_ADDR) begin
                    nxt_bus = rps_pkg::BUS_REG;
                end else begin
                    nxt_bus = rps_pkg::BUS_WR;
                end
            end else if (bus_ff == rps_pkg::BUS_RD) begin
                if (cnt_ff == 4'd9) begin
                    nxt_cnt = 4'd0;
                    nxt_drv = ~sh_ff[7];
                end else if (cnt_ff == 4'd8) begin
                    nxt_drv = 1'b0;
                end else if (cnt_ff != 4'd0) begin
                    nxt_sh  = {sh_ff[6:0], 1'b0};
                    nxt_drv = ~sh_ff[6];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // both sets load the same per-buck code (see R06)
            regs_ff[0]  <= `RPS_BUCK_RAIL_1_RST;
            regs_ff[1]  <= `RPS_BUCK_RAIL_2_RST;
            regs_ff[2]  <= `RPS_BUCK_RAIL_3_RST;
            regs_ff[3]  <= `RPS_BUCK_RAIL_4_RST;
            regs_ff[4]  <= `RPS_BUCK_RAIL_1_RST;
            regs_ff[5]  <= `RPS_BUCK_RAIL_2_RST;
            regs_ff[6]  <= `RPS_BUCK_RAIL_3_RST;
            regs_ff[7]  <= `RPS_BUCK_RAIL_4_RST;
            regs_ff[8]  <= `RPS_LIN1_RST;
            regs_ff[9]  <= `RPS_LIN2_RST;
            regs_ff[10] <= `RPS_LIN3_RST;
            bus_ff      <= rps_pkg::BUS_IDLE;
            sh_ff       <= 8'h00;
            cnt_ff      <= 4'd0;
            ptr_ff      <= 8'h00;
            drv_ff      <= 1'b0;
            rw_ff       <= 1'b0;
            scl_q_ff    <= 1'b1;
            sda_q_ff    <= 1'b1;
        end else begin
            regs_ff     <= nxt_regs;
            bus_ff      <= nxt_bus;
            sh_ff       <= nxt_sh;
            cnt_ff      <= nxt_cnt;
            ptr_ff      <= nxt_ptr;
            drv_ff      <= nxt_drv;
            rw_ff       <= nxt_rw;
            scl_q_ff    <= scl_s;
            sda_q_ff    <= sda_s;
        end
    end

    // open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = drv_ff;

    // ----------------------------------------
    // voltage selection and decode
    // ----------------------------------------
    rps_pkg::rps_vout_t vout_ff;
    rps_pkg::rps_vout_t nxt_vout;
    logic [3:0][7:0]    buck_code;

    generate
        for (genvar b = 0; b < 4; b++) begin : g_buck
            assign buck_code[b] = dvs_s ? regs_ff[4 + b] : regs_ff[b]; // see R05
        end
    endgenerate

    always_comb begin
        logic [21:0] uv;
        uv       = 22'h000000;
        nxt_vout = vout_ff;
        for (int b = 0; b < 3; b++) begin
            uv = `RPS_BUCK_BASE_UV + 22'(buck_code[b] * `RPS_BUCK_STEP_UV);   // see R08
            nxt_vout.buck_uv[b] = (uv > `RPS_BUCK_TOP_UV) ? `RPS_BUCK_TOP_UV : uv;
        end
        nxt_vout.buck_rail_4_code = buck_code[3];
        // 6-bit codes top out at 3.575 V and 2.375 V exactly
        nxt_vout.lin_mv[0] = `RPS_LIN13_BASE_MV + 12'(regs_ff[8][5:0] * `RPS_LIN_STEP_MV);
        nxt_vout.lin_mv[1] = `RPS_LIN2_BASE_MV + 12'(regs_ff[9][5:0] * `RPS_LIN_STEP_MV);
        nxt_vout.lin_mv[2] = `RPS_LIN13_BASE_MV + 12'(regs_ff[10][5:0] * `RPS_LIN_STEP_MV);
    end                                                                // see R09 see R10

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vout_ff <= '0;
        end else begin
            vout_ff <= nxt_vout;
        end
    end

    assign vout_o = vout_ff;

endmodule

// *** dv/rps_sva.sv ***
`timescale 1ns/1ps
module rps_sva (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       seq_trigger_i,
    input wire logic [6:0] rail_pg_i,
    input wire logic [6:0] rail_en_o,
    input wire logic       system_reset_out_n_o,
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       power_good_pin_o,
    input wire logic       input_supply_ok_pin_o,
    input wire logic       external_supply_enable_o,
    input wire logic       aux_reset_one_o,
    input wire logic       aux_reset_two_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // cycles since any power-good moved, saturating so it never wraps
    logic [9:0] gap_ff;
    logic [9:0] nxt_gap;
    logic [6:0] pg_q_ff;
    always_comb nxt_gap = (rail_pg_i != pg_q_ff) ? 10'h000 : gap_ff + {9'h000, gap_ff != 10'h3FF};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_ff  <= 10'h000;
            pg_q_ff <= 7'h00;
        end else begin
            gap_ff  <= nxt_gap;
            pg_q_ff <= rail_pg_i;
        end
    end

    property p_kill;
        !seq_trigger_i [*4] |-> rail_en_o == 7'h00;
    endproperty
    a_kill: assert property (p_kill) else $error("rail on while trigger low");
    property p_thermo;
        (rail_en_o & (rail_en_o + 7'h01)) == 7'h00;
    endproperty
    a_thermo: assert property (p_thermo) else $error("rail enabled out of order");
    property p_gap;
        $changed(rail_en_o) && rail_en_o > 7'h01 |-> gap_ff >= 10'd95 && gap_ff <= 10'd210;
    endproperty
    a_gap: assert property (p_gap) else $error("start delay off");
    property p_rst_gap;
        $rose(system_reset_out_n_o) |-> gap_ff >= 10'd195 && gap_ff <= 10'd310;
    endproperty
    a_rst_gap: assert property (p_rst_gap) else $error("reset release delay off");
    property p_rst_hold;
        $rose(system_reset_out_n_o) |-> $past(rail_pg_i[6]) && rail_en_o == 7'h7F;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released early");
    property p_rst_low;
        rail_en_o != 7'h7F |-> !system_reset_out_n_o;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset high with rails off");
    property p_unused;
        {power_good_pin_o, input_supply_ok_pin_o, external_supply_enable_o,
         aux_reset_one_o, aux_reset_two_o} == 5'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused pin active");
    property p_sda;
        $changed(sda_oe_o) |-> !scl_i && !sda_o;
    endproperty
    a_sda: assert property (p_sda) else $error("data line moved while clock high");

    c_up: cover property ($rose(system_reset_out_n_o));
    c_abort: cover property ($past(rail_en_o) == 7'h0F && rail_en_o == 7'h00);
    c_ack: cover property ($rose(sda_oe_o));
endmodule

bind rps_sequencer rps_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .seq_trigger_i(seq_trigger_i),
    .rail_pg_i(rail_pg_i), .rail_en_o(rail_en_o), .system_reset_out_n_o(system_reset_out_n_o),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .power_good_pin_o(power_good_pin_o),
    .input_supply_ok_pin_o(input_supply_ok_pin_o),
    .external_supply_enable_o(external_supply_enable_o),
    .aux_reset_one_o(aux_reset_one_o), .aux_reset_two_o(aux_reset_two_o));

// *** dv/rps_rail_model.sv ***
`timescale 1ns/1ps
// power-good follows enable after lag_i cycles and drops at once
module rps_rail_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [6:0] rail_en_i,
    input  wire logic [7:0] lag_i,
    output logic      [6:0] rail_pg_o
);
    logic [6:0][7:0] cnt_ff;
    logic [6:0][7:0] nxt_cnt;
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            nxt_cnt[k] = (cnt_ff[k] != lag_i) ? cnt_ff[k] + 8'h01 : cnt_ff[k];
            if (!rail_en_i[k])
                nxt_cnt[k] = 8'h00;
            rail_pg_o[k] = rail_en_i[k] && cnt_ff[k] == lag_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule

// *** dv/rps_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`include "rps_cfg.svh"
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module rps_sequencer_tb_top;
    logic               clk_i, rst_n_i, trig, dynamic_voltage_scaling, pwr_en, scl, msda, rst_out_n, sda_oe, sda_out;
    logic [7:0]         lag;
    logic [6:0]         pg, en;
    logic [4:0]         unused;
    rps_pkg::rps_vout_t vout;
    int                 n_fail, checks_done, cyc;
    wire                sda_w = msda & (~sda_oe | sda_out);

    always #5 clk_i = ~clk_i;

    rps_sequencer #(.START_DELAY_US(2), .RST_DELAY_US(3)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .seq_trigger_i(trig), .dvs_select_in_i(dynamic_voltage_scaling),
        .power_enable_in_i(pwr_en), .mode_i(1'b0), .rail_pg_i(pg), .rail_en_o(en),
        .system_reset_out_n_o(rst_out_n), .vout_o(vout), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .power_good_pin_o(unused[0]),
        .input_supply_ok_pin_o(unused[1]), .external_supply_enable_o(unused[2]),
        .aux_reset_one_o(unused[3]), .aux_reset_two_o(unused[4]));
    rps_rail_model u_rail (.clk_i(clk_i), .rst_n_i(rst_n_i), .rail_en_i(en), .lag_i(lag),
        .rail_pg_o(pg));

    // ----------------------------------------
    // serial port master
    // ----------------------------------------
    task automatic bus(input logic c, input logic d);
        scl  = c;
        msda = d;
        repeat (8) @(negedge clk_i);
    endtask
    task automatic i2c_start();
        bus(1'b0, 1'b1);
        bus(1'b1, 1'b1);
        bus(1'b1, 1'b0);
        bus(1'b0, 1'b0);
    endtask
    task automatic i2c_stop();
        bus(1'b0, 1'b0);
        bus(1'b1, 1'b0);
        bus(1'b1, 1'b1);
    endtask
    // nine bits, the last one released, so reads always end with a not-acknowledge
    task automatic xfer(input logic [7:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            bus(1'b0, (i == 0) ? 1'b1 : tx[i - 1]);
            bus(1'b1, (i == 0) ? 1'b1 : tx[i - 1]);
            rx[i] = sda_w;
            bus(1'b0, (i == 0) ? 1'b1 : tx[i - 1]);
        end
    endtask
    task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        i2c_start();
        xfer(8'hA6, r);
        `CHK("write address ack", r[0], 1'b0)
        xfer(a, r);
        if (rd) begin
            i2c_start();
            xfer(8'hA7, r);
            `CHK("read address ack", r[0], 1'b0)
        end
        xfer(rd ? 8'hFF : d, r);
        if (rd)
            `CHK("register read", r[8:1], d)
        i2c_stop();
    endtask

    function automatic logic [21:0] uv(input logic [7:0] c);
        return 22'd600000 + 22'd9375 * c;
    endfunction

    task automatic power_up(input logic [7:0] lg);
        int t;
        int lo;
        lag  = lg;
        trig = 1'b1;
        for (int k = 0; k < 8; k++) begin
            lo     = (k == 0) ? 95 : lg + ((k == 7) ? 195 : 95);
            pwr_en = ~pwr_en;
            for (t = 0; t < 600 && ((k < 7) ? en[k] : rst_out_n) !== 1'b1; t++)
                @(negedge clk_i);
            `CHK("step delay", t >= lo && t <= lo + 115, 1'b1)
            if (k < 7)
                `CHK("rail order", en, (7'h01 << (k + 1)) - 7'h01)
        end
        `CHK("all rails up", en, 7'h7F)
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // whole run needs about 11000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        logic [8:0] r;
        int         t;
        clk_i       = 1'b0;
        rst_n_i     = 1'b0;
        trig        = 1'b0;
        dynamic_voltage_scaling         = 1'b0;
        pwr_en      = 1'b1;
        scl         = 1'b1;
        msda        = 1'b1;
        lag         = 8'h05;
        n_fail      = 0;
        checks_done = 0;
        cyc         = 0;
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK("buck_rail_1 uv", vout.buck_uv[0], uv(`RPS_BUCK_RAIL_1_RST))
        `CHK("buck_rail_2 uv", vout.buck_uv[1], uv(`RPS_BUCK_RAIL_2_RST))
        `CHK("buck_rail_3 uv", vout.buck_uv[2], uv(`RPS_BUCK_RAIL_3_RST))
        `CHK("lin1 mv", vout.lin_mv[0], 12'd2000)
        `CHK("lin2 mv", vout.lin_mv[1], 12'd900)
        `CHK("lin3 mv", vout.lin_mv[2], 12'd2000)
        dynamic_voltage_scaling = 1'b1;
        repeat (6) @(negedge clk_i);
        `CHK("alt buck_rail_2 uv", vout.buck_uv[1], uv(`RPS_BUCK_RAIL_2_RST))
        `CHK("alt buck_rail_4", vout.buck_rail_4_code, `RPS_BUCK_RAIL_4_RST)
        $display("test defaults done");
        acc(1'b1, 8'h7D, `RPS_ID_VALUE);
        acc(1'b0, 8'h7D, 8'h00);
        acc(1'b1, 8'h7D, `RPS_ID_VALUE);
        acc(1'b1, 8'h20, 8'h00);
        i2c_start();
        xfer(8'hA8, r);
        `CHK("foreign address nack", r[0], 1'b1)
        i2c_stop();
        $display("test serial done");
        acc(1'b0, 8'h04, 8'h10);
        `CHK("alternate set", vout.buck_uv[0], uv(8'h10))
        dynamic_voltage_scaling = 1'b0;
        repeat (6) @(negedge clk_i);
        `CHK("primary set", vout.buck_uv[0], uv(`RPS_BUCK_RAIL_1_RST))
        acc(1'b0, 8'h00, 8'h00);
        `CHK("buck base", vout.buck_uv[0], 22'd600000)
        acc(1'b0, 8'h08, 8'h3F);
        `CHK("lin1 top", vout.lin_mv[0], 12'd3575)
        acc(1'b0, 8'h09, 8'h3F);
        `CHK("lin2 top", vout.lin_mv[1], 12'd2375)
        $display("test voltage sets done");
        power_up(8'h05);
        acc(1'b1, `RPS_REG_RAIL_STAT, 8'h7F);
        trig = 1'b0;
        repeat (4) @(negedge clk_i);
        `CHK("all off", {en, rst_out_n}, 8'h00)
        trig = 1'b1;
        for (t = 0; t < 2000 && en[3] !== 1'b1; t++)
            @(negedge clk_i);
        `CHK("abort reached", en, 7'h0F)
        trig = 1'b0;
        repeat (4) @(negedge clk_i);
        `CHK("abort mid chain", {en, rst_out_n}, 8'h00)
        repeat (8) @(negedge clk_i);
        power_up(8'h3C);
        `CHK("unused pins", unused, 5'h00)
        $display("test sequencing done");
        end_of_test();
    end
endmodule
